// ---- bench/net_side_model.sv ----
`timescale 1ns/1ps
// network side: address bits and frame status strobes
module net_side_model
  import mac_hash_pkg::*;
(
  input  wire logic mclk,
  output logic      rx_frame_start,
  output logic      rx_bit_valid,
  output logic      rx_bit,
  output logic      rx_frame_end,
  output logic      rx_addr_match,
  output logic      rx_align_err,
  output logic      rx_crc_err,
  output logic      rx_no_buffer
);
  initial begin
    {rx_frame_start, rx_bit_valid, rx_bit, rx_frame_end} = 4'h0;
    {rx_addr_match, rx_align_err, rx_crc_err, rx_no_buffer} = 4'h0;
  end

  // one bit a cycle; the line is inverted after the last bit so no stale value looks real
  task automatic send(input logic [47:0] da);
    @(posedge mclk);
    rx_frame_start <= 1'b1;
    for (int i = 0; i < DA_BITS; i++) begin
      @(posedge mclk);
      rx_frame_start <= 1'b0;
      rx_bit_valid   <= 1'b1;
      rx_bit         <= da[i];
    end
    @(posedge mclk);
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~da[DA_BITS-1];
  endtask

  // status levels only mean something beside the end strobe
  task automatic finish(input logic m, input logic a, input logic c, input logic nb);
    @(posedge mclk);
    rx_frame_end  <= 1'b1;
    rx_addr_match <= m;
    rx_align_err  <= a;
    rx_crc_err    <= c;
    rx_no_buffer  <= nb;
    @(posedge mclk);
    rx_frame_end  <= 1'b0;
    rx_addr_match <= ~m;
    rx_align_err  <= ~a;
    rx_crc_err    <= ~c;
    rx_no_buffer  <= 1'b0;
    #1;
  endtask
endmodule

// ---- bench/tb_mac_hash_filter_tally_init.sv ----
`timescale 1ns/1ps
module tb_mac_hash_filter_tally_init;
  import mac_hash_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata_ff;
  logic       rx_frame_start, rx_bit_valid, rx_bit, rx_frame_end;
  logic       rx_addr_match, rx_align_err, rx_crc_err, rx_no_buffer;
  logic       loop_byte_valid = 1'b0;
  logic [7:0] loop_byte = 8'h00;
  logic       tx_collision = 1'b0;
  logic       tx_done = 1'b0;
  logic       tx_excess_coll = 1'b0;
  logic       hash_valid_ff, mcast_accept_ff, running_ff, tx_start_ff;
  logic       loop_internal_ff, loop_external_ff;
  int         err_count = 0;
  int         n_tests = 0;
  int         hv_cnt = 0;
  int         go_cnt = 0;

  always #5 mclk = ~mclk;

  mac_hash_filter_tally_init u_mac_hash_filter_tally_init (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .rx_frame_start(rx_frame_start),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_frame_end(rx_frame_end),
    .rx_addr_match(rx_addr_match), .rx_align_err(rx_align_err), .rx_crc_err(rx_crc_err),
    .rx_no_buffer(rx_no_buffer), .loop_byte_valid(loop_byte_valid), .loop_byte(loop_byte),
    .tx_collision(tx_collision), .tx_done(tx_done), .tx_excess_coll(tx_excess_coll),
    .hash_valid_ff(hash_valid_ff), .mcast_accept_ff(mcast_accept_ff), .running_ff(running_ff),
    .tx_start_ff(tx_start_ff), .loop_internal_ff(loop_internal_ff), .loop_external_ff(loop_external_ff));

  net_side_model u_net_side_model (
    .mclk(mclk), .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_frame_end(rx_frame_end), .rx_addr_match(rx_addr_match), .rx_align_err(rx_align_err),
    .rx_crc_err(rx_crc_err), .rx_no_buffer(rx_no_buffer));

  // pulse outputs are counted here so scenarios can look at totals afterwards
  always @(posedge mclk) begin
    if (hash_valid_ff === 1'b1) hv_cnt++;
    if (tx_start_ff === 1'b1) go_cnt++;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    n_tests++;
    if (reg_rdata_ff !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, reg_rdata_ff);
    end
  endtask

  // own crc model, group flag first
  function automatic logic [5:0] hash_of(input logic [47:0] da);
    logic [31:0] c;
    c = CRC_PRESET;
    for (int i = 0; i < DA_BITS; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction

  task automatic t_defaults;
    rd_chk("command", OFS_COMMAND, 8'h21);
    rd_chk("data_config", OFS_DATA_CONFIG, 8'h08);
    rd_chk("event_status", OFS_EVENT_STAT, 8'h80);
    rd_chk("event_mask", OFS_EVENT_MASK, 8'h00);
    rd_chk("tx_config", OFS_TX_CONFIG, 8'h00);
    rd_chk("unmapped", 5'h1f, 8'h00);
    chk1("running", 1'b0, running_ff);
  endtask

  // idle until run; a frame before run gets no decision
  task automatic t_init;
    int h0;
    h0 = hv_cnt;
    wr(OFS_COMMAND, 8'h21);
    wr(OFS_DATA_CONFIG, 8'h08);
    wr(OFS_RX_CONFIG, 8'h00);
    wr(OFS_TX_CONFIG, 8'h02);
    @(posedge mclk);
    #1;
    chk1("loop internal", 1'b1, loop_internal_ff);
    wr(OFS_EVENT_STAT, 8'hff);
    rd_chk("event_status cleared", OFS_EVENT_STAT, 8'h00);
    wr(OFS_EVENT_MASK, 8'h00);
    u_net_side_model.send(48'h0000_0000_0001);
    u_net_side_model.finish(1'b0, 1'b0, 1'b0, 1'b0);
    chk1("decision while halted", 1'b1, hv_cnt == h0);
    wr(OFS_COMMAND, 8'h61);
    wr(OFS_COMMAND, 8'h22);
    chk1("running", 1'b1, running_ff);
    rd_chk("halt cleared", OFS_COMMAND, 8'h22);
    wr(OFS_TX_CONFIG, 8'h04);
    @(posedge mclk);
    #1;
    chk1("loop external", 1'b1, loop_external_ff);
    wr(OFS_TX_CONFIG, 8'h00);
  endtask

  // every filter bit set except the hashed one, then its byte holds that one alone
  task automatic t_hash;
    logic [47:0] da;
    logic [5:0]  h;
    int          h0;
    da = 48'h5a3c_0000_0a01;
    h  = hash_of(da);
    for (int n = 0; n < 8; n++) begin
      wr(OFS_HASH_BASE + 5'(n), (n == h[5:3]) ? ~(8'h01 << h[2:0]) : 8'hff);
    end
    u_net_side_model.send(da);
    u_net_side_model.finish(1'b0, 1'b0, 1'b0, 1'b0);
    chk1("reject unset bit", 1'b0, mcast_accept_ff);
    wr(OFS_HASH_BASE + 5'(h[5:3]), 8'h01 << h[2:0]);
    h0 = hv_cnt;
    u_net_side_model.send(da);
    u_net_side_model.finish(1'b0, 1'b0, 1'b0, 1'b0);
    chk1("accept set bit", 1'b1, mcast_accept_ff);
    chk1("group decision", 1'b1, hv_cnt == h0 + 1);
    h0 = hv_cnt;
    u_net_side_model.send(da ^ 48'h1);
    u_net_side_model.finish(1'b0, 1'b0, 1'b0, 1'b0);
    chk1("physical no decision", 1'b1, hv_cnt == h0);
    chk1("physical not accepted", 1'b0, mcast_accept_ff);
  endtask

  task automatic t_tally;
    u_net_side_model.finish(1'b0, 1'b1, 1'b1, 1'b0);
    u_net_side_model.finish(1'b1, 1'b1, 1'b0, 1'b1);
    rd_chk("align count", OFS_ALIGN_TALLY, 8'h01);
    rd_chk("cksum count", OFS_CKSUM_TALLY, 8'h00);
    rd_chk("lost count", OFS_LOST_TALLY, 8'h01);
    rd_chk("align cleared", OFS_ALIGN_TALLY, 8'h00);
    repeat (200) u_net_side_model.finish(1'b1, 1'b1, 1'b1, 1'b1);
    rd_chk("align sat", OFS_ALIGN_TALLY, TALLY_MAX);
    rd_chk("cksum sat", OFS_CKSUM_TALLY, TALLY_MAX);
    rd_chk("lost sat", OFS_LOST_TALLY, TALLY_MAX);
    rd_chk("cksum cleared", OFS_CKSUM_TALLY, 8'h00);
    wr(OFS_RX_CONFIG, 8'h20);
    u_net_side_model.finish(1'b1, 1'b0, 1'b0, 1'b0);
    u_net_side_model.finish(1'b0, 1'b0, 1'b0, 1'b1);
    u_net_side_model.finish(1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk("monitor count", OFS_LOST_TALLY, 8'h02);
    wr(OFS_RX_CONFIG, 8'h00);
  endtask

  // ten bytes in, only the last eight come out, oldest first
  task automatic t_loop;
    wr(OFS_TX_CONFIG, 8'h02);
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      loop_byte_valid <= 1'b1;
      loop_byte       <= 8'h30 + 8'(i);
    end
    @(posedge mclk);
    loop_byte_valid <= 1'b0;
    loop_byte       <= 8'hc6;
    for (int i = 0; i < 8; i++) begin
      rd_chk("loop byte", OFS_LOOP_PORT, 8'h32 + 8'(i));
    end
    wr(OFS_TX_CONFIG, 8'h00);
  endtask

  task automatic t_retry;
    int g0;
    rd_chk("retry idle", OFS_RETRY_COUNT, 8'h00);
    rd_chk("status idle", OFS_TX_STATUS, 8'h00);
    @(posedge mclk);
    tx_collision <= 1'b1;
    repeat (3) @(posedge mclk);
    tx_collision <= 1'b0;
    rd_chk("retry three", OFS_RETRY_COUNT, 8'h03);
    rd_chk("collided", OFS_TX_STATUS, 8'h04);
    g0 = go_cnt;
    wr(OFS_COMMAND, 8'h26);
    rd_chk("retry after go", OFS_RETRY_COUNT, 8'h00);
    chk1("go pulse", 1'b1, go_cnt == g0 + 1);
    @(posedge mclk);
    tx_collision <= 1'b1;
    repeat (2) @(posedge mclk);
    tx_collision   <= 1'b0;
    tx_excess_coll <= 1'b1;
    @(posedge mclk);
    tx_excess_coll <= 1'b0;
    rd_chk("retry after abort", OFS_RETRY_COUNT, 8'h00);
    rd_chk("abort status", OFS_TX_STATUS, 8'h0c);
  endtask

  // the whole run is under a thousand cycles; 20000 cycles leave ample margin
  initial begin
    #200_000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_defaults();
    t_init();
    t_hash();
    t_tally();
    t_loop();
    t_retry();
    give_verdict();
  end
endmodule

// ---- hdl/mac_hash_filter_tally_init.sv ----
`timescale 1ns/1ps
module mac_hash_filter_tally_init
  import mac_hash_pkg::*;
#(
  parameter int LOOP_DEPTH = 8
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_ff,
  input  wire logic       rx_frame_start,
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_bit,
  input  wire logic       rx_frame_end,
  input  wire logic       rx_addr_match,
  input  wire logic       rx_align_err,
  input  wire logic       rx_crc_err,
  input  wire logic       rx_no_buffer,
  input  wire logic       loop_byte_valid,
  input  wire logic [7:0] loop_byte,
  input  wire logic       tx_collision,
  input  wire logic       tx_done,
  input  wire logic       tx_excess_coll,
  output logic            hash_valid_ff,
  output logic            mcast_accept_ff,
  output logic            running_ff,
  output logic            tx_start_ff,
  output logic            loop_internal_ff,
  output logic            loop_external_ff
);

  localparam int PTR_W = $clog2(LOOP_DEPTH);

  // pointer wrap needs a power of two depth; any depth other than 8 is refused at elaboration
  if (LOOP_DEPTH != 8) begin : g_depth_check
    $error("LOOP_DEPTH must be 8");
  end

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ADDR = 2'b01,
    RX_REST = 2'b10
  } rx_state_t;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v >= TALLY_MAX) ? TALLY_MAX : v + 8'h01;
  endfunction

  // tally step: a read clears, but an event in the same cycle still counts
  function automatic logic [7:0] tally_next(input logic [7:0] v, input logic rd, input logic ev);
    logic [7:0] base;
    base = rd ? ZERO_BYTE : v;
    tally_next = ev ? sat_inc(base) : base;
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ d) ? CRC_POLY : 32'h00000000);
  endfunction

  logic [7:0]  cmd_ff, dcr_ff, tcr_ff, rcr_ff, isr_ff, imr_ff, tsr_ff;
  logic [3:0]  retry_ff;
  logic [7:0]  align_ff, cksum_ff, lost_ff;
  logic [7:0]  hash_ff [8];
  logic [7:0]  loop_mem [LOOP_DEPTH];
  logic [PTR_W-1:0] loop_wr_ff, loop_rd_ff;
  logic [31:0] crc_ff;
  logic [5:0]  bit_cnt_ff;
  logic        group_ff;
  rx_state_t   rx_state_ff;

  // address decode
  wire wr_cmd   = reg_wr && (reg_addr == OFS_COMMAND);
  wire wr_dcr   = reg_wr && (reg_addr == OFS_DATA_CONFIG);
  wire wr_tcr   = reg_wr && (reg_addr == OFS_TX_CONFIG);
  wire wr_rcr   = reg_wr && (reg_addr == OFS_RX_CONFIG);
  wire wr_isr   = reg_wr && (reg_addr == OFS_EVENT_STAT);
  wire wr_imr   = reg_wr && (reg_addr == OFS_EVENT_MASK);
  wire wr_hash  = reg_wr && (reg_addr[4:3] == OFS_HASH_BASE[4:3]);
  wire rd_align = reg_rd && (reg_addr == OFS_ALIGN_TALLY);
  wire rd_cksum = reg_rd && (reg_addr == OFS_CKSUM_TALLY);
  wire rd_lost  = reg_rd && (reg_addr == OFS_LOST_TALLY);
  wire rd_loop  = reg_rd && (reg_addr == OFS_LOOP_PORT);

  // command decode: halt wins over run if both written
  wire go_write  = wr_cmd && reg_wdata[CMD_GO_BIT];
  wire halt_wr   = wr_cmd && reg_wdata[CMD_HALT_BIT];
  wire run_wr    = wr_cmd && reg_wdata[CMD_RUN_BIT] && !reg_wdata[CMD_HALT_BIT];
  wire tx_finish = tx_done || tx_excess_coll;
  wire [7:0] nxt_cmd;
  assign nxt_cmd[7:3] = wr_cmd ? reg_wdata[7:3] : cmd_ff[7:3];
  assign nxt_cmd[CMD_HALT_BIT] = halt_wr ? 1'b1 : (run_wr ? 1'b0 : cmd_ff[CMD_HALT_BIT]);
  assign nxt_cmd[CMD_RUN_BIT]  = halt_wr ? 1'b0 : (run_wr ? 1'b1 : cmd_ff[CMD_RUN_BIT]);
  assign nxt_cmd[CMD_GO_BIT]   = go_write || (cmd_ff[CMD_GO_BIT] && !tx_finish);

  // command and configuration registers, reset defaults
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= CMD_RESET;
      dcr_ff <= DCR_RESET;
      tcr_ff <= ZERO_BYTE;
      rcr_ff <= ZERO_BYTE;
      imr_ff <= ZERO_BYTE;
      isr_ff <= ISR_RESET;
    end else begin
      cmd_ff <= nxt_cmd;
      if (wr_dcr) dcr_ff <= reg_wdata;
      if (wr_tcr) tcr_ff <= reg_wdata;
      if (wr_rcr) rcr_ff <= reg_wdata;
      if (wr_imr) imr_ff <= reg_wdata;
      if (wr_isr) isr_ff <= isr_ff & ~reg_wdata;  // write one to clear
    end
  end

  // block outputs: only the transmit start waits for the run command; loop selects follow tx_config
  wire [1:0] loop_code = {tcr_ff[LOOP_HI_BIT], tcr_ff[LOOP_LO_BIT]};
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      running_ff       <= 1'b0;
      tx_start_ff      <= 1'b0;
      loop_internal_ff <= 1'b0;
      loop_external_ff <= 1'b0;
    end else begin
      running_ff       <= nxt_cmd[CMD_RUN_BIT];
      tx_start_ff      <= go_write && nxt_cmd[CMD_RUN_BIT];
      loop_internal_ff <= (loop_code == LOOP_INTERNAL);
      loop_external_ff <= (loop_code == LOOP_EXTERNAL);
    end
  end

  // destination address hashing; collects bits only from frames that start while running
  wire addr_bit   = (rx_state_ff == RX_ADDR) && rx_bit_valid;
  wire last_bit   = addr_bit && (bit_cnt_ff == 6'(DA_BITS - 1));
  wire [31:0] crc_nxt = crc_step(crc_ff, rx_bit);
  wire [5:0]  hash_idx = crc_nxt[31:26];
  wire [7:0]  hash_sel = hash_ff[hash_idx[5:3]];
  wire        group_now = (bit_cnt_ff == 6'h00) ? rx_bit : group_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_ff <= RX_IDLE;
      crc_ff      <= CRC_PRESET;
      bit_cnt_ff  <= 6'h00;
      group_ff    <= 1'b0;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          if (rx_frame_start && running_ff) begin
            rx_state_ff <= RX_ADDR;
            crc_ff      <= CRC_PRESET;
            bit_cnt_ff  <= 6'h00;
          end
        end
        RX_ADDR: begin
          if (addr_bit) begin
            crc_ff     <= crc_nxt;
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
            group_ff   <= group_now;
            if (last_bit) rx_state_ff <= RX_REST;
          end
          if (rx_frame_end) rx_state_ff <= RX_IDLE;
        end
        RX_REST: begin
          if (rx_frame_end) rx_state_ff <= RX_IDLE;
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // filter decision: group addresses only; a physical one clears the accept flag with no valid strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hash_valid_ff   <= 1'b0;
      mcast_accept_ff <= 1'b0;
    end else begin
      hash_valid_ff   <= last_bit && group_now;
      if (last_bit) mcast_accept_ff <= group_now && hash_sel[hash_idx[2:0]];
    end
  end

  // filter bank; no reset value is defined, cleared for determinism
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) hash_ff[i] <= ZERO_BYTE;
    end else if (wr_hash) begin
      hash_ff[reg_addr[2:0]] <= reg_wdata;
    end
  end

  // tally events
  wire mon_mode  = rcr_ff[MONITOR_BIT];
  wire recog_end = rx_frame_end && rx_addr_match;
  wire ev_align  = recog_end && rx_align_err;
  wire ev_cksum  = recog_end && rx_crc_err;
  wire ev_lost   = mon_mode ? recog_end : rx_no_buffer;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      align_ff <= ZERO_BYTE;
      cksum_ff <= ZERO_BYTE;
      lost_ff  <= ZERO_BYTE;
    end else begin
      align_ff <= tally_next(align_ff, rd_align, ev_align);
      cksum_ff <= tally_next(cksum_ff, rd_cksum, ev_cksum);
      lost_ff  <= tally_next(lost_ff, rd_lost, ev_lost);
    end
  end

  // loopback store: ring overwrites, so the last bytes remain
  always_ff @(posedge mclk) begin
    if (loop_byte_valid) loop_mem[loop_wr_ff] <= loop_byte;
  end

  // each incoming byte restarts the read order at the oldest kept byte, unless a read comes in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      loop_wr_ff <= '0;
      loop_rd_ff <= '0;
    end else begin
      if (loop_byte_valid) loop_wr_ff <= loop_wr_ff + 1'b1;
      if (rd_loop) loop_rd_ff <= loop_rd_ff + 1'b1;
      else if (loop_byte_valid) loop_rd_ff <= loop_wr_ff + 1'b1;
    end
  end

  // retry count and transmit status; a collision beside a go write still counts
  wire [3:0] retry_base = go_write ? 4'h0 : retry_ff;
  wire [3:0] retry_inc  = (retry_base == RETRY_MAX) ? RETRY_MAX : retry_base + 4'h1;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      retry_ff <= 4'h0;
      tsr_ff   <= ZERO_BYTE;
    end else begin
      if (tx_excess_coll) retry_ff <= 4'h0;
      else if (tx_collision) retry_ff <= retry_inc;
      else retry_ff <= retry_base;
      if (go_write) tsr_ff <= ZERO_BYTE;
      if (tx_excess_coll) tsr_ff[TXS_ABORT_BIT] <= 1'b1;
      if (tx_collision) tsr_ff[TXS_COLLIDE_BIT] <= 1'b1;
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = ZERO_BYTE;
    case (reg_addr)
      OFS_COMMAND:     rd_mux = cmd_ff;
      OFS_DATA_CONFIG: rd_mux = dcr_ff;
      OFS_TX_CONFIG:   rd_mux = tcr_ff;
      OFS_RX_CONFIG:   rd_mux = rcr_ff;
      OFS_EVENT_STAT:  rd_mux = isr_ff;
      OFS_EVENT_MASK:  rd_mux = imr_ff;
      OFS_TX_STATUS:   rd_mux = tsr_ff;
      OFS_RETRY_COUNT: rd_mux = {4'h0, retry_ff};
      OFS_ALIGN_TALLY: rd_mux = align_ff;
      OFS_CKSUM_TALLY: rd_mux = cksum_ff;
      OFS_LOST_TALLY:  rd_mux = lost_ff;
      OFS_LOOP_PORT:   rd_mux = loop_mem[loop_rd_ff];
      default: begin
        if (reg_addr[4:3] == OFS_HASH_BASE[4:3]) rd_mux = hash_ff[reg_addr[2:0]];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) reg_rdata_ff <= ZERO_BYTE;
    else reg_rdata_ff <= reg_rd ? rd_mux : ZERO_BYTE;
  end

  // checks
  sequence run_written_s;
    run_wr;
  endsequence

  sequence runs_next_s;
    ##1 running_ff && !cmd_ff[CMD_HALT_BIT];
  endsequence

  tally_cap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    align_ff <= TALLY_MAX && cksum_ff <= TALLY_MAX && lost_ff <= TALLY_MAX)
    else $error("tally above cap");

  tally_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_align && !ev_align |=> align_ff == 8'h00 && reg_rdata_ff == $past(align_ff))
    else $error("tally read did not clear");

  align_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ev_align && !rd_align && align_ff < TALLY_MAX |=> align_ff == $past(align_ff) + 8'h01)
    else $error("alignment tally missed");

  cksum_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !recog_end && !rd_cksum |=> $stable(cksum_ff))
    else $error("checksum tally moved");

  lost_mode_a: assert property (@(posedge mclk) disable iff (!rst_b)
    mon_mode && recog_end && !rd_lost && lost_ff < TALLY_MAX |=> lost_ff == $past(lost_ff) + 8'h01)
    else $error("monitor count missed");

  excess_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_excess_coll |=> retry_ff == 4'h0 && tsr_ff[TXS_ABORT_BIT])
    else $error("abort not flagged");

  go_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    go_write && !tx_collision |=> retry_ff == 4'h0)
    else $error("retry count not cleared");

  run_halt_a: assert property (@(posedge mclk) disable iff (!rst_b)
    run_written_s |-> runs_next_s)
    else $error("run did not clear halt");

  idle_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tx_start_ff |-> running_ff && $past(go_write))
    else $error("transmit while halted");

  hash_pick_a: assert property (@(posedge mclk) disable iff (!rst_b)
    last_bit && group_now |=> mcast_accept_ff == $past(hash_sel[hash_idx[2:0]]) && hash_valid_ff)
    else $error("filter decision wrong");

  loop_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
    loop_code == LOOP_INTERNAL |=> loop_internal_ff && !loop_external_ff)
    else $error("loop select wrong");

  loop_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_loop |=> loop_rd_ff == PTR_W'($past(loop_rd_ff) + 1'b1))
    else $error("loop pointer stuck");

endmodule

// ---- pkg/mac_hash_pkg.sv ----
package mac_hash_pkg;
  // register offsets on the plain register port
  localparam logic [4:0] OFS_COMMAND     = 5'h00;
  localparam logic [4:0] OFS_DATA_CONFIG = 5'h01;
  localparam logic [4:0] OFS_TX_CONFIG   = 5'h02;
  localparam logic [4:0] OFS_RX_CONFIG   = 5'h03;
  localparam logic [4:0] OFS_EVENT_STAT  = 5'h04;
  localparam logic [4:0] OFS_EVENT_MASK  = 5'h05;
  localparam logic [4:0] OFS_TX_STATUS   = 5'h06;
  localparam logic [4:0] OFS_RETRY_COUNT = 5'h07;
  localparam logic [4:0] OFS_ALIGN_TALLY = 5'h08;
  localparam logic [4:0] OFS_CKSUM_TALLY = 5'h09;
  localparam logic [4:0] OFS_LOST_TALLY  = 5'h0a;
  localparam logic [4:0] OFS_LOOP_PORT   = 5'h0b;
  localparam logic [4:0] OFS_HASH_BASE   = 5'h10;  // eight bytes, 0x10..0x17

  // command_reg fields
  localparam int CMD_HALT_BIT  = 0;
  localparam int CMD_RUN_BIT   = 1;
  localparam int CMD_GO_BIT    = 2;
  localparam int CMD_ABORT_BIT = 5;
  localparam logic [7:0] CMD_RESET = 8'h21;

  // other field positions
  localparam int LONG_ADDR_BIT   = 3;
  localparam int LOOP_LO_BIT     = 1;
  localparam int LOOP_HI_BIT     = 2;
  localparam int MONITOR_BIT     = 5;
  localparam int RESET_FLAG_BIT  = 7;
  localparam int TXS_COLLIDE_BIT = 2;
  localparam int TXS_ABORT_BIT   = 3;

  localparam logic [7:0] DCR_RESET  = 8'h08;
  localparam logic [7:0] ISR_RESET  = 8'h80;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // filter and tally figures
  localparam int          DA_BITS     = 48;
  localparam int          HASH_BITS   = 6;
  localparam logic [7:0]  TALLY_MAX   = 8'hc0;
  localparam logic [3:0]  RETRY_MAX   = 4'hf;
  localparam logic [31:0] CRC_POLY    = 32'h04c11db7;
  localparam logic [31:0] CRC_PRESET  = 32'hffffffff;

  // loop select codes
  localparam logic [1:0] LOOP_INTERNAL = 2'h1;
  localparam logic [1:0] LOOP_EXTERNAL = 2'h2;
endpackage
